// file: logic/drive_cmd_pkg.sv
// constants and types shared by the drive command input logic
`default_nettype none
package drive_cmd_pkg;
  // ---------------------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CONTROL_RESET = 32'h0040_0000;

  // control field positions
  localparam int CTL_SCHEME_LSB = 0;
  localparam int CTL_OPTION_BIT = 3;
  localparam int CTL_PLACE_LSB = 4;
  localparam int CTL_RESPONSE_LSB = 6;
  localparam int CTL_REFSRC_LSB = 8;
  localparam int CTL_DCCUR_LSB = 16;

  // status field positions
  localparam int ST_RUN = 0;
  localparam int ST_REVERSE = 1;
  localparam int ST_COAST = 2;
  localparam int ST_WARNING = 3;
  localparam int ST_EXT_FAULT = 4;
  localparam int ST_DC_BRAKE = 5;
  localparam int ST_PLACE_LSB = 6;
  localparam int ST_PRESET_LSB = 8;
  localparam int ST_MODE2 = 11;
  localparam int ST_NEED_OPEN = 12;

  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SCHEME_DUAL_START = 3'h0;
  localparam logic [2:0] SCHEME_RUN_DIRECTION = 3'h1;
  localparam logic [2:0] SCHEME_RUN_PERMIT = 3'h2;
  localparam logic [2:0] SCHEME_PULSE = 3'h3;
  localparam logic [2:0] SCHEME_POT_RAISE = 3'h4;
  localparam logic [2:0] SCHEME_EDGE_DUAL = 3'h5;
  localparam logic [2:0] SCHEME_EDGE_DIRECTION = 3'h6;
  localparam logic [2:0] SCHEME_EDGE_PERMIT = 3'h7;

  localparam logic [1:0] PLACE_TERMINAL = 2'h0;
  localparam logic [1:0] PLACE_KEYPAD = 2'h1;
  localparam logic [1:0] PLACE_FIELDBUS = 2'h2;

  localparam logic [4:0] REFSRC_ANALOG_SELECT = 5'hE;

  // edge-detected inputs
  localparam int EDGE_COUNT = 3;
  localparam int EDGE_CMD1 = 0;
  localparam int EDGE_CMD2 = 1;
  localparam int EDGE_FAULT_RESET = 2;
  localparam logic [2:0] EDGE_PREV_RESET = 3'h7;

  typedef enum logic [1:0] {STOPPED, RUN_FWD, RUN_REV} term_state_e;
endpackage
`default_nettype wire

// file: logic/input_edges_if.sv
// raw levels and edge pulses of the edge-watched contact inputs
`default_nettype none
interface input_edges_if;
  import drive_cmd_pkg::*;
  logic [EDGE_COUNT-1:0] level;
  logic [EDGE_COUNT-1:0] rise;
  logic [EDGE_COUNT-1:0] fall;
  modport producer(output level, output rise, output fall);
  modport consumer(input level, input rise, input fall);
endinterface
`default_nettype wire

// file: logic/input_edge_detect.sv
// edge detector for the contact inputs whose transitions matter
`default_nettype none
module input_edge_detect
  import drive_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [EDGE_COUNT-1:0] raw,
  input_edges_if.producer edges
);
  logic [EDGE_COUNT-1:0] prev;

  // previous value resets high so a contact already closed at power-up
  // is never mistaken for a fresh closure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= EDGE_PREV_RESET;
    end else begin
      prev <= raw;
    end
  end

  genvar i;
  generate
    for (i = 0; i < EDGE_COUNT; i++) begin : g_bit
      assign edges.level[i] = raw[i];
      assign edges.rise[i] = raw[i] & ~prev[i];
      assign edges.fall[i] = ~raw[i] & prev[i];
    end
  endgenerate
endmodule
`default_nettype wire

// file: logic/drive_run_command_input_logic.sv
// run, stop, direction, reference and configuration decoding of drive contacts
`default_nettype none
// Overview of operation
// - terminal place uses configured start/stop scheme
// - scheme 0 forward/reverse, first direction wins
// - scheme 1 run level, second input direction
// - scheme 2 run level, second input permits
// - scheme 3 start pulse, falling stop
// - scheme 4 first starts, second raises pot
// - scheme 5 starts only on rising edges
// - scheme 6 like 1, rising edge start
// - scheme 7 like 2, rising edge start
// - edge schemes need start input seen open
// - permit removal coasts, blocks, warns
// - reverse input used where no direction input
// - three preset inputs form binary index
// - pot down lowers while held closed
// - fault reset acts on rising edge only
// - either external fault input raises fault
// - ramp select open set 1, closed 2
// - ramp hold freezes; option allows deceleration
// - stopped and input closed gives braking
// - swap input picks analogue or secondary source
// - forced place overrides, stored place kept
// - bank switch only when stopped, load/save
// - mode select open mode 1, closed 2
module drive_run_command_input_logic
  import drive_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // contacts
  input wire logic first_command_input,
  input wire logic second_command_input,
  input wire logic run_permit_input,
  input wire logic reverse_input,
  input wire logic [2:0] preset_speed_input,
  input wire logic pot_raise_input,
  input wire logic pot_lower_input,
  input wire logic fault_reset_input,
  input wire logic ext_fault_close_input,
  input wire logic ext_fault_open_input,
  input wire logic ramp_set_input,
  input wire logic ramp_hold_input,
  input wire logic dc_braking_input,
  input wire logic ref_swap_input,
  input wire logic force_terminal_input,
  input wire logic force_fieldbus_input,
  input wire logic force_keypad_input,
  input wire logic config_bank_select,
  input wire logic control_scheme_select,
  // commands from the other control places
  input wire logic keypad_run,
  input wire logic keypad_reverse,
  input wire logic fieldbus_run,
  input wire logic fieldbus_reverse,
  // requests to the drive
  output logic run_request,
  output logic reverse_request,
  output logic coast_stop,
  output logic permit_warning,
  output logic [1:0] active_place,
  output logic [2:0] preset_index,
  output logic pot_raise,
  output logic pot_lower,
  output logic fault_reset_pulse,
  output logic ext_fault,
  output logic [1:0] ext_fault_response,
  output logic ramp_set2,
  output logic ramp_freeze,
  output logic allow_decel_in_hold,
  output logic dc_brake_active,
  output logic [7:0] dc_brake_current,
  output logic analog2_select,
  output logic secondary_ref_select,
  output logic bank_load_pulse,
  output logic bank_save_pulse,
  output logic control_mode2
);
  // ---------------------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------------------
  function automatic logic carries_direction(input logic [2:0] s);
    carries_direction = (s == SCHEME_DUAL_START) || (s == SCHEME_RUN_DIRECTION) ||
                        (s == SCHEME_EDGE_DUAL) || (s == SCHEME_EDGE_DIRECTION);
  endfunction

  function automatic logic edge_scheme(input logic [2:0] s);
    edge_scheme = (s == SCHEME_EDGE_DUAL) || (s == SCHEME_EDGE_DIRECTION) ||
                  (s == SCHEME_EDGE_PERMIT);
  endfunction

  function automatic term_state_e dir_state(input logic rev);
    dir_state = rev ? RUN_REV : RUN_FWD;
  endfunction

  // ---------------------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] control;
  logic [2:0] scheme;
  logic option_bit;
  logic [1:0] stored_place;
  logic [4:0] ref_source;

  assign scheme = control[CTL_SCHEME_LSB +: 3];
  assign option_bit = control[CTL_OPTION_BIT];
  assign stored_place = control[CTL_PLACE_LSB +: 2];
  assign ref_source = control[CTL_REFSRC_LSB +: 5];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CONTROL_RESET;
    end else if (wr && addr == CONTROL_OFFSET) begin
      control <= wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // edge detection of command and reset contacts
  // ---------------------------------------------------------------------------
  input_edges_if edges();

  input_edge_detect u_edges (
    .clk(clk),
    .rst_n(rst_n),
    .raw({fault_reset_input, second_command_input, first_command_input}),
    .edges(edges.producer)
  );

  logic in1;
  logic in2;
  logic rise1;
  logic rise2;
  logic fall2;
  logic reset_edge;

  assign in1 = edges.level[EDGE_CMD1];
  assign in2 = edges.level[EDGE_CMD2];
  assign rise1 = edges.rise[EDGE_CMD1];
  assign rise2 = edges.rise[EDGE_CMD2];
  assign fall2 = edges.fall[EDGE_CMD2];
  assign reset_edge = edges.rise[EDGE_FAULT_RESET];

  // ---------------------------------------------------------------------------
  // control place
  // ---------------------------------------------------------------------------
  logic [1:0] next_place;

  always_comb begin
    if (force_terminal_input) begin
      next_place = PLACE_TERMINAL;
    end else if (force_fieldbus_input) begin
      next_place = PLACE_FIELDBUS;
    end else if (force_keypad_input) begin
      next_place = PLACE_KEYPAD;
    end else begin
      next_place = stored_place;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_place <= PLACE_TERMINAL;
    end else begin
      active_place <= next_place;
    end
  end

  // ---------------------------------------------------------------------------
  // faults and permit
  // ---------------------------------------------------------------------------
  logic fault_latched;

  // an opening-contact input reports the fault while it is open
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_latched <= 1'b0;
    end else if (ext_fault_close_input || !ext_fault_open_input) begin
      fault_latched <= 1'b1;
    end else if (reset_edge) begin
      fault_latched <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset_pulse <= 1'b0;
      coast_stop <= 1'b0;
      permit_warning <= 1'b0;
    end else begin
      fault_reset_pulse <= reset_edge;
      coast_stop <= !run_permit_input;
      permit_warning <= !run_permit_input;
    end
  end

  assign ext_fault = fault_latched;
  assign ext_fault_response = control[CTL_RESPONSE_LSB +: 2];

  // ---------------------------------------------------------------------------
  // terminal start/stop schemes
  // ---------------------------------------------------------------------------
  term_state_e term_state;
  term_state_e next_term_state;
  logic need_open;
  logic armed;
  logic running;
  logic blocked;

  assign armed = !need_open;
  assign running = (term_state != STOPPED);
  assign blocked = !run_permit_input || fault_latched || (next_place != PLACE_TERMINAL);

  always_comb begin
    next_term_state = term_state;
    case (scheme)
      SCHEME_DUAL_START: begin
        case (term_state)
          STOPPED: next_term_state = in1 ? RUN_FWD : (in2 ? RUN_REV : STOPPED);
          RUN_FWD: next_term_state = in1 ? RUN_FWD : (in2 ? RUN_REV : STOPPED);
          RUN_REV: next_term_state = in2 ? RUN_REV : (in1 ? RUN_FWD : STOPPED);
          default: next_term_state = STOPPED;
        endcase
      end
      SCHEME_RUN_DIRECTION: begin
        next_term_state = in1 ? dir_state(in2) : STOPPED;
      end
      SCHEME_RUN_PERMIT: begin
        next_term_state = (in1 && in2) ? dir_state(reverse_input) : STOPPED;
      end
      SCHEME_PULSE: begin
        if (fall2 || !in2) begin
          next_term_state = STOPPED;
        end else if (running || rise1) begin
          next_term_state = dir_state(reverse_input);
        end
      end
      SCHEME_POT_RAISE: begin
        next_term_state = in1 ? dir_state(reverse_input) : STOPPED;
      end
      SCHEME_EDGE_DUAL: begin
        case (term_state)
          STOPPED: begin
            if (armed && rise1) begin
              next_term_state = RUN_FWD;
            end else if (armed && rise2) begin
              next_term_state = RUN_REV;
            end
          end
          RUN_FWD: next_term_state = in1 ? RUN_FWD : STOPPED;
          RUN_REV: next_term_state = in2 ? RUN_REV : STOPPED;
          default: next_term_state = STOPPED;
        endcase
      end
      SCHEME_EDGE_DIRECTION: begin
        if (!in1) begin
          next_term_state = STOPPED;
        end else if (running || (armed && rise1)) begin
          next_term_state = dir_state(in2);
        end
      end
      SCHEME_EDGE_PERMIT: begin
        if (!(in1 && in2)) begin
          next_term_state = STOPPED;
        end else if (running || (armed && rise1)) begin
          next_term_state = dir_state(reverse_input);
        end
      end
      default: next_term_state = STOPPED;
    endcase
    if (blocked) begin
      next_term_state = STOPPED;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_state <= STOPPED;
    end else begin
      term_state <= next_term_state;
    end
  end

  // start contact must be seen open after power-up, fault reset, a permit
  // stop or a place change; the arming event wins over a same-cycle open
  logic permit_stop;
  logic open_seen;

  assign permit_stop = !run_permit_input ||
                       (running && !in2 &&
                        (scheme == SCHEME_RUN_PERMIT || scheme == SCHEME_EDGE_PERMIT));
  assign open_seen = (scheme == SCHEME_EDGE_DUAL) ? (!in1 && !in2) : !in1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      need_open <= 1'b1;
    end else if (reset_edge || permit_stop || next_place != active_place) begin
      need_open <= 1'b1;
    end else if (open_seen || !edge_scheme(scheme)) begin
      need_open <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // run and direction towards the drive
  // ---------------------------------------------------------------------------
  logic next_run;
  logic next_reverse;

  always_comb begin
    case (next_place)
      PLACE_KEYPAD: begin
        next_run = keypad_run;
        next_reverse = keypad_reverse;
      end
      PLACE_FIELDBUS: begin
        next_run = fieldbus_run;
        next_reverse = fieldbus_reverse;
      end
      default: begin
        next_run = (next_term_state != STOPPED);
        next_reverse = carries_direction(scheme) ? (next_term_state == RUN_REV) :
                       reverse_input;
      end
    endcase
    if (!run_permit_input || fault_latched) begin
      next_run = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_request <= 1'b0;
      reverse_request <= 1'b0;
    end else begin
      run_request <= next_run;
      reverse_request <= next_reverse;
    end
  end

  // ---------------------------------------------------------------------------
  // reference, ramp and braking requests
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_index <= 3'h0;
      pot_raise <= 1'b0;
      pot_lower <= 1'b0;
      ramp_set2 <= 1'b0;
      ramp_freeze <= 1'b0;
      allow_decel_in_hold <= 1'b0;
      analog2_select <= 1'b0;
      secondary_ref_select <= 1'b0;
    end else begin
      preset_index <= preset_speed_input;
      pot_raise <= pot_raise_input || (scheme == SCHEME_POT_RAISE &&
                   next_place == PLACE_TERMINAL && in2);
      pot_lower <= pot_lower_input;
      ramp_set2 <= ramp_set_input;
      ramp_freeze <= ramp_hold_input;
      allow_decel_in_hold <= ramp_hold_input && option_bit;
      analog2_select <= (ref_source == REFSRC_ANALOG_SELECT) && ref_swap_input;
      secondary_ref_select <= (ref_source != REFSRC_ANALOG_SELECT) && ref_swap_input;
    end
  end

  // braking is held off the moment a run is requested
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dc_brake_active <= 1'b0;
    end else begin
      dc_brake_active <= dc_braking_input && !next_run && !run_request;
    end
  end

  assign dc_brake_current = control[CTL_DCCUR_LSB +: 8];

  // ---------------------------------------------------------------------------
  // parameter bank and control mode
  // ---------------------------------------------------------------------------
  logic bank_applied;

  // a change made while running waits here until the drive stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_applied <= 1'b0;
      bank_load_pulse <= 1'b0;
      bank_save_pulse <= 1'b0;
    end else begin
      bank_load_pulse <= 1'b0;
      bank_save_pulse <= 1'b0;
      if (!run_request && config_bank_select != bank_applied) begin
        bank_applied <= config_bank_select;
        bank_load_pulse <= !config_bank_select;
        bank_save_pulse <= config_bank_select;
      end
    end
  end

  // loop-mode changes are left to the operator to make at standstill
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_mode2 <= 1'b0;
    end else begin
      control_mode2 <= control_scheme_select;
    end
  end

  // ---------------------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] status;

  always_comb begin
    status = '0;
    status[ST_RUN] = run_request;
    status[ST_REVERSE] = reverse_request;
    status[ST_COAST] = coast_stop;
    status[ST_WARNING] = permit_warning;
    status[ST_EXT_FAULT] = fault_latched;
    status[ST_DC_BRAKE] = dc_brake_active;
    status[ST_PLACE_LSB +: 2] = active_place;
    status[ST_PRESET_LSB +: 3] = preset_index;
    status[ST_MODE2] = control_mode2;
    status[ST_NEED_OPEN] = need_open;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        CONTROL_OFFSET: rdata <= control;
        STATUS_OFFSET: rdata <= status;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// file: bench/contact_field_model.sv
// field contact model driving the command, permit, fault and mode lines
`default_nettype none
module contact_field_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic running,
  input wire logic [5:0] want,
  output logic [5:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // contacts
  // ----
  // bit 4 is an opening contact: the line sits high while healthy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line <= 6'h14;
    end else begin
      line[4:0] <= want[4:0] ^ 5'h10;
      if (!running) begin
        line[5] <= want[5];
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/drive_run_command_input_logic_checker.sv
// port assertions for the drive command input logic
`default_nettype none
module drive_run_command_input_logic_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_permit_input,
  input wire logic coast_stop,
  input wire logic permit_warning,
  input wire logic run_request,
  input wire logic fault_reset_input,
  input wire logic fault_reset_pulse,
  input wire logic ext_fault_close_input,
  input wire logic ext_fault_open_input,
  input wire logic ext_fault,
  input wire logic [2:0] preset_speed_input,
  input wire logic [2:0] preset_index,
  input wire logic control_scheme_select,
  input wire logic control_mode2,
  input wire logic ramp_set_input,
  input wire logic ramp_set2,
  input wire logic dc_brake_active,
  input wire logic bank_load_pulse,
  input wire logic bank_save_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_reset_rise;
    !fault_reset_input ##1 fault_reset_input;
  endsequence
  a_reset_edge_pulse:
    assert property (s_reset_rise |=> fault_reset_pulse ##1 !fault_reset_pulse)
    else $error("fault reset pulse missing");
  a_reset_level_quiet:
    assert property (!$rose(fault_reset_input) |=> !fault_reset_pulse)
    else $error("fault reset pulse without edge");
  a_fault_stays_latched:
    assert property (ext_fault && !$rose(fault_reset_input) |=> ext_fault)
    else $error("fault cleared without edge");
  a_ext_fault_set:
    assert property ((ext_fault_close_input || !ext_fault_open_input) |=> ext_fault)
    else $error("external fault not raised");
  a_permit_coast_warn:
    assert property (!run_permit_input |=> coast_stop && permit_warning && !run_request)
    else $error("permit loss not handled");
  a_preset_index_follow:
    assert property (1'b1 |=> preset_index == $past(preset_speed_input))
    else $error("preset index wrong");
  a_mode_select_follow:
    assert property ($changed(control_scheme_select) |=>
                     control_mode2 == $past(control_scheme_select))
    else $error("control mode wrong");
  a_ramp_set_follow:
    assert property ($changed(ramp_set_input) |=> ramp_set2 == $past(ramp_set_input))
    else $error("ramp set wrong");
  a_brake_only_stopped:
    assert property (dc_brake_active |-> !run_request)
    else $error("braking while running");
  a_bank_run_idle:
    assert property (run_request && $past(run_request) |-> !bank_load_pulse && !bank_save_pulse)
    else $error("bank switch while running");
endmodule
`default_nettype wire

// file: bench/drive_run_command_input_logic_test.sv
// self-checking testbench for the drive command input logic
`default_nettype none
module drive_run_command_input_logic_test;
  import drive_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, tie = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [5:0] want = 6'h04, line;
  logic reverse_input = 1'b0, fault_reset_input = 1'b0, ramp_set_input = 1'b0;
  logic dc_braking_input = 1'b0, force_terminal_input = 1'b0, force_keypad_input = 1'b0;
  logic config_bank_select = 1'b0, keypad_run = 1'b0;
  logic [2:0] preset_speed_input = 3'h0, preset_index;
  logic first_command_input, second_command_input, run_permit_input;
  logic ext_fault_close_input, ext_fault_open_input, control_scheme_select;
  logic run_request, reverse_request, coast_stop, permit_warning, fault_reset_pulse;
  logic ext_fault, ramp_set2, dc_brake_active, control_mode2, bank_load_pulse, bank_save_pulse;
  logic [1:0] active_place;
  logic [7:0] fl;
  logic pot_raise, pot_lower, ramp_freeze, allow_decel_in_hold, analog2_select;
  logic secondary_ref_select;
  logic [5:0] aux;
  int err_total = 0, checks_done = 0;
  assign {control_scheme_select, ext_fault_open_input, ext_fault_close_input,
          run_permit_input, second_command_input, first_command_input} = line;
  assign fl = {dc_brake_active, ramp_set2, control_mode2, ext_fault, permit_warning,
               coast_stop, reverse_request, run_request};
  assign aux = {secondary_ref_select, analog2_select, allow_decel_in_hold, ramp_freeze,
                pot_lower, pot_raise};
  always #5 clk = ~clk;
  contact_field_model field (.clk, .rst_n, .running(run_request), .want, .line);
  drive_run_command_input_logic dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .first_command_input, .second_command_input, .run_permit_input, .reverse_input,
    .preset_speed_input, .pot_raise_input(tie[0]), .pot_lower_input(tie[1]),
    .fault_reset_input, .ext_fault_close_input, .ext_fault_open_input, .ramp_set_input,
    .ramp_hold_input(tie[2]), .dc_braking_input, .ref_swap_input(tie[3]),
    .force_terminal_input, .force_fieldbus_input(tie[4]), .force_keypad_input,
    .config_bank_select, .control_scheme_select, .keypad_run, .keypad_reverse(tie[5]),
    .fieldbus_run(tie[6]), .fieldbus_reverse(tie[7]), .run_request, .reverse_request,
    .coast_stop, .permit_warning, .active_place, .preset_index, .pot_raise, .pot_lower,
    .fault_reset_pulse, .ext_fault, .ext_fault_response(), .ramp_set2, .ramp_freeze,
    .allow_decel_in_hold, .dc_brake_active, .dc_brake_current(), .analog2_select,
    .secondary_ref_select, .bank_load_pulse, .bank_save_pulse, .control_mode2);
  // ----
  // helpers
  // ----
  task automatic complete_run;
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
    // back on the next edge so that stimulus stays edge aligned
    @(posedge clk);
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic scheme(logic [2:0] s);
    wr_reg(CONTROL_OFFSET, CONTROL_RESET | {29'h0, s});
    wait_n(1);
  endtask
  task automatic step(logic [5:0] w, logic [7:0] e);
    want <= w;
    wait_n(3);
    #1 chk({24'h0, fl}, {24'h0, e});
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    wr_reg(STATUS_OFFSET, 32'hFFFF_FFFF);
    rd_chk(CONTROL_OFFSET, CONTROL_RESET);
    rd_chk(8'h10, 32'h0);
  endtask
  task automatic t_level_schemes;
    scheme(SCHEME_RUN_DIRECTION);
    step(6'h07, 8'h03);
    step(6'h05, 8'h01);
    step(6'h04, 8'h00);
    scheme(SCHEME_DUAL_START);
    step(6'h05, 8'h01);
    step(6'h07, 8'h01);
    step(6'h04, 8'h00);
  endtask
  task automatic t_edge_start;
    scheme(SCHEME_EDGE_DIRECTION);
    step(6'h01, 8'h0C);
    step(6'h05, 8'h00);
    step(6'h04, 8'h00);
    step(6'h07, 8'h03);
    step(6'h04, 8'h00);
  endtask
  task automatic t_pulse;
    scheme(SCHEME_PULSE);
    step(6'h06, 8'h00);
    step(6'h07, 8'h01);
    step(6'h06, 8'h01);
    step(6'h04, 8'h00);
  endtask
  task automatic t_fault;
    step(6'h0C, 8'h10);
    step(6'h04, 8'h10);
    fault_reset_input <= 1'b1;
    step(6'h04, 8'h00);
    step(6'h14, 8'h10);
    step(6'h04, 8'h10);
    fault_reset_input <= 1'b0;
    wait_n(1);
    fault_reset_input <= 1'b1;
    step(6'h04, 8'h00);
    fault_reset_input <= 1'b0;
  endtask
  task automatic t_preset_bank;
    for (int i = 0; i < 8; i++) begin
      preset_speed_input <= 3'(i);
      wait_n(1);
      #1 chk({29'h0, preset_index}, 32'(i));
    end
    config_bank_select <= 1'b1;
    wait_n(1);
    #1 chk({30'h0, bank_load_pulse, bank_save_pulse}, 32'h1);
    config_bank_select <= 1'b0;
    wait_n(1);
    #1 chk({30'h0, bank_load_pulse, bank_save_pulse}, 32'h2);
    #1 chk({30'h0, bank_load_pulse, bank_save_pulse}, 32'h0);
  endtask
  task automatic t_levels_force;
    logic [31:0] cfg;
    cfg = CONTROL_RESET | {19'h0, REFSRC_ANALOG_SELECT, 5'h01, SCHEME_POT_RAISE};
    wr_reg(CONTROL_OFFSET, cfg);
    rd_chk(CONTROL_OFFSET, cfg);
    ramp_set_input <= 1'b1;
    dc_braking_input <= 1'b1;
    tie[3:1] <= 3'h7;
    step(6'h26, 8'hE0);
    #1 chk({26'h0, aux}, 32'h1F);
    rd_chk(STATUS_OFFSET, 32'h0000_0F20);
    ramp_set_input <= 1'b0;
    dc_braking_input <= 1'b0;
    tie <= 8'h00;
    force_keypad_input <= 1'b1;
    keypad_run <= 1'b1;
    step(6'h04, 8'h01);
    #1 chk({30'h0, active_place}, {30'h0, PLACE_KEYPAD});
    force_terminal_input <= 1'b1;
    step(6'h04, 8'h00);
    #1 chk({30'h0, active_place}, {30'h0, PLACE_TERMINAL});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_n(1);
    t_regs();
    t_level_schemes();
    t_edge_start();
    t_pulse();
    t_fault();
    t_preset_bank();
    t_levels_force();
    complete_run();
  end
  initial begin
    #200us;
    err_total++;
    complete_run();
  end
endmodule
bind drive_run_command_input_logic drive_run_command_input_logic_checker chk_i (.clk,
  .rst_n, .run_permit_input, .coast_stop, .permit_warning, .run_request,
  .fault_reset_input, .fault_reset_pulse, .ext_fault_close_input, .ext_fault_open_input,
  .ext_fault, .preset_speed_input, .preset_index, .control_scheme_select, .control_mode2,
  .ramp_set_input, .ramp_set2, .dc_brake_active, .bank_load_pulse, .bank_save_pulse);
`default_nettype wire
